// ===== hdl/dbm_pkg.sv
// Shared constants, types and helpers of the burst DDR memory link.
`default_nettype none
package dbm_pkg;
  // ****************************************
  // Widths and organisation
  // ****************************************
  localparam int DQ_W = 36;
  localparam int HALF_W = 18;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 4;
  localparam int ROW_W = 13;
  localparam int MASK_W = 2;
  localparam int WSTB_N = 2;
  localparam int RSTB_N = 4;
  localparam int BEAT_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_HOST_W = 2 + DQ_W;
  localparam int SYNC_DEV_W = 4 + BANK_W + ADDR_W + WSTB_N + MASK_W + DQ_W;
  // ****************************************
  // Burst length codes
  // ****************************************
  localparam logic [1:0] LEN_CODE_2 = 2'h0;
  localparam logic [1:0] LEN_CODE_4 = 2'h1;
  localparam logic [1:0] LEN_CODE_8 = 2'h2;
  localparam logic [1:0] LEN_CODE_BAD = 2'h3;
  localparam logic [1:0] LEN_CODE_RST = LEN_CODE_2;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int LINK_NS = 800;
  localparam int CK_DIV = LINK_NS / CLK_NS;
  localparam logic [2:0] PH_LAST = 3'(CK_DIV - 1);
  localparam logic [2:0] PH_FALL = 3'(CK_DIV / 2);
  localparam int REF_WINDOW_NS = 64000000;
  localparam int REF_PER_WINDOW = 131072;
  localparam int REFI_RAW = REF_WINDOW_NS / (REF_PER_WINDOW * CLK_NS);
  localparam int REFI_CYC = (REFI_RAW < 1) ? 1 : REFI_RAW;
  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_MODE, OP_REFRESH} dbm_op_t;
  localparam logic [2:0] PINS_NOP = 3'h7;

  // Beats in one burst for a length code.
  function automatic logic [BEAT_W-1:0] dbm_burst_beat_count(input logic [1:0] code);
    case (code)
      LEN_CODE_2: return 4'h2;
      LEN_CODE_4: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction

  // Select, write and refresh pin levels {cs_n, we_n, ref_n} for a command.
  function automatic logic [2:0] dbm_pins(input dbm_op_t op);
    case (op)
      OP_READ: return 3'h3;
      OP_WRITE: return 3'h1;
      OP_REFRESH: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== hdl/dbm_link_if.sv
// Link between the memory-device end and the controller end.
`timescale 1ns/100ps
`default_nettype none
interface dbm_link_if
  import dbm_pkg::*;
  ();
  logic ck;
  logic cs_n;
  logic we_n;
  logic ref_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [WSTB_N-1:0] write_data_strobe;
  logic [MASK_W-1:0] write_byte_mask;
  logic [RSTB_N-1:0] read_data_strobe;
  logic [DQ_W-1:0] dq_h;
  logic dq_h_oe;
  logic [DQ_W-1:0] dq_d;
  logic dq_d_oe;
  logic [DQ_W-1:0] dq;

  // Level of the shared data wires from the two output enables.
  assign dq = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : '0);

  modport host_mp (
    output ck, cs_n, we_n, ref_n, bank, addr, write_data_strobe, write_byte_mask,
    output dq_h, dq_h_oe,
    input dq, read_data_strobe
  );
  modport dev_mp (
    input ck, cs_n, we_n, ref_n, bank, addr, write_data_strobe, write_byte_mask,
    input dq,
    output dq_d, dq_d_oe, read_data_strobe
  );
endinterface
`default_nettype wire

// ===== hdl/dbm_fifo.sv
// Parameterised word FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module dbm_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic in_rdy_reg, in_rdy_next, out_vld_reg, out_vld_next;
  logic push, pop;

  always_comb begin
    push = in_valid_i & in_rdy_reg;
    pop = out_ready_i & out_vld_reg;
    wp_next = push ? wp_reg + AW'(1) : wp_reg;
    rp_next = pop ? rp_reg + AW'(1) : rp_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    in_rdy_next = (cnt_next != (AW+1)'(DEPTH));
    out_vld_next = (cnt_next != '0);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      in_rdy_reg <= 1'b1;
      out_vld_reg <= 1'b0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      in_rdy_reg <= in_rdy_next;
      out_vld_reg <= out_vld_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  assign in_ready_o = in_rdy_reg;
  assign out_valid_o = out_vld_reg;
  assign out_data_o = mem[rp_reg];
  assign count_o = cnt_reg;
endmodule // dbm_fifo
`default_nettype wire

// ===== hdl/dbm_device_end.sv
// Memory-device end: sixteen-bank burst DDR storage behind the link.
// Functional notes
// - Each data pin moves two bits per clock.
// - Read data launched together with read strobes.
// - Commands sampled only on link clock rise.
// - Write data captured on both strobe edges.
// - Bursts of two, four or eight beats.
// - Sixteen banks chosen by bank field.
// - Refresh row generated inside the device.
// - Controller runs device with locked loop enabled.
// - Controller never issues undefined command combinations.
// - Full address sent with every command.
// - Four read strobes, nine data bits each.
// - Two-strobe controller uses strobes zero and one.
// - Controller issues at most one refresh per two link clocks; ticks while one is pending are lost.
// - Write mask blocks masked data from storage.
`timescale 1ns/100ps
`default_nettype none
module dbm_device_end
  import dbm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  dbm_link_if.dev_mp link,
  output logic [1:0] burst_code_o,
  output logic refresh_pulse_o,
  output logic [BANK_W-1:0] refresh_bank_o,
  output logic [ROW_W-1:0] refresh_row_o,
  output logic write_pulse_o
);
  typedef enum logic [1:0] {DS_IDLE, DS_WRITE, DS_READ} dbm_dstate_t;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_DEV_W-1:0] sync1_reg;
  logic [SYNC_DEV_W-1:0] sync2_reg;
  logic ck_d_reg;
  logic [WSTB_N-1:0] wstb_d_reg;
  logic ck_s;
  logic cs_n_s;
  logic we_n_s;
  logic ref_n_s;
  logic [BANK_W-1:0] bank_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WSTB_N-1:0] wstb_s;
  logic [MASK_W-1:0] mask_s;
  logic [DQ_W-1:0] dq_s;
  logic ck_rise;
  logic ck_edge;
  logic [WSTB_N-1:0] wedge;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ck_d_reg <= 1'b0;
      wstb_d_reg <= '0;
    end else begin
      sync1_reg <= {link.ck, link.cs_n, link.we_n, link.ref_n, link.bank, link.addr,
                    link.write_data_strobe, link.write_byte_mask, link.dq};
      sync2_reg <= sync1_reg;
      ck_d_reg <= ck_s;
      wstb_d_reg <= wstb_s;
    end
  end

  always_comb begin
    {ck_s, cs_n_s, we_n_s, ref_n_s, bank_s, addr_s, wstb_s, mask_s, dq_s} = sync2_reg;
    ck_rise = ck_s & ~ck_d_reg;
    ck_edge = ck_s ^ ck_d_reg;
    wedge = wstb_s ^ wstb_d_reg;
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [DQ_W-1:0] mem [256];
  logic [ROW_W-1:0] rows_reg [16];

  // Word index: bank, then address advanced by the beat, wrapping in the bank.
  function automatic logic [7:0] word_index(input logic [BANK_W-1:0] b,
                                            input logic [ADDR_W-1:0] a,
                                            input logic [BEAT_W-1:0] beat);
    return {b, a + beat};
  endfunction

  // ****************************************
  // Command and burst engine
  // ****************************************
  dbm_dstate_t state_reg, state_next;
  logic [BEAT_W-1:0] beat_reg, beat_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [HALF_W-1:0] lo_reg, lo_next;
  logic [1:0] code_reg, code_next;
  logic [DQ_W-1:0] dq_reg, dq_next;
  logic oe_reg, oe_next;
  logic rstb_reg, rstb_next;
  logic rpulse_reg, rpulse_next;
  logic [BANK_W-1:0] rbank_reg, rbank_next;
  logic [ROW_W-1:0] rrow_reg, rrow_next;
  logic wpulse_reg, wpulse_next;
  logic mem_we;
  logic [7:0] mem_idx;
  logic [DQ_W-1:0] mem_wdata;
  logic [DQ_W-1:0] beat_data;
  logic row_we;
  logic [BEAT_W-1:0] burst_beats;
  logic [2:0] pins;

  always_comb begin
    state_next = state_reg;
    beat_next = beat_reg;
    bank_next = bank_reg;
    addr_next = addr_reg;
    lo_next = lo_reg;
    code_next = code_reg;
    dq_next = dq_reg;
    oe_next = oe_reg;
    rstb_next = rstb_reg;
    rpulse_next = 1'b0;
    rbank_next = rbank_reg;
    rrow_next = rrow_reg;
    wpulse_next = 1'b0;
    mem_we = 1'b0;
    row_we = 1'b0;
    mem_idx = word_index(bank_reg, addr_reg, beat_reg);
    beat_data = {dq_s[DQ_W-1:HALF_W], wedge[0] ? dq_s[HALF_W-1:0] : lo_reg};
    mem_wdata = {mask_s[1] ? mem[mem_idx][DQ_W-1:HALF_W] : beat_data[DQ_W-1:HALF_W],
                 mask_s[0] ? mem[mem_idx][HALF_W-1:0] : beat_data[HALF_W-1:0]};
    burst_beats = dbm_burst_beat_count(code_reg);
    pins = {cs_n_s, we_n_s, ref_n_s};
    case (state_reg)
      DS_IDLE: begin
        if (ck_rise) begin
          if (pins == dbm_pins(OP_READ)) begin
            state_next = DS_READ;
            beat_next = '0;
            bank_next = bank_s;
            addr_next = addr_s;
          end else if (pins == dbm_pins(OP_WRITE)) begin
            state_next = DS_WRITE;
            beat_next = '0;
            bank_next = bank_s;
            addr_next = addr_s;
          end else if (pins == dbm_pins(OP_REFRESH)) begin
            row_we = 1'b1;
            rpulse_next = 1'b1;
            rbank_next = bank_s;
            rrow_next = rows_reg[bank_s];
          end else if (pins == dbm_pins(OP_MODE)) begin
            if (addr_s[1:0] != LEN_CODE_BAD) begin
              code_next = addr_s[1:0];
            end
          end
        end
      end
      DS_WRITE: begin
        if (wedge[0]) begin
          lo_next = dq_s[HALF_W-1:0];
        end
        if (wedge[1]) begin
          mem_we = 1'b1;
          wpulse_next = 1'b1;
          beat_next = beat_reg + 4'h1;
          if (beat_reg + 4'h1 == burst_beats) begin
            state_next = DS_IDLE;
          end
        end
      end
      DS_READ: begin
        if (ck_edge) begin
          if (beat_reg == burst_beats) begin
            oe_next = 1'b0;
            state_next = DS_IDLE;
          end else begin
            dq_next = mem[mem_idx];
            rstb_next = ~rstb_reg;
            oe_next = 1'b1;
            beat_next = beat_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= DS_IDLE;
      beat_reg <= '0;
      bank_reg <= '0;
      addr_reg <= '0;
      lo_reg <= '0;
      code_reg <= LEN_CODE_RST;
      dq_reg <= '0;
      oe_reg <= 1'b0;
      rstb_reg <= 1'b0;
      rpulse_reg <= 1'b0;
      rbank_reg <= '0;
      rrow_reg <= '0;
      wpulse_reg <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        rows_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      beat_reg <= beat_next;
      bank_reg <= bank_next;
      addr_reg <= addr_next;
      lo_reg <= lo_next;
      code_reg <= code_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      rstb_reg <= rstb_next;
      rpulse_reg <= rpulse_next;
      rbank_reg <= rbank_next;
      rrow_reg <= rrow_next;
      wpulse_reg <= wpulse_next;
      if (row_we) begin
        rows_reg[bank_s] <= rows_reg[bank_s] + ROW_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.dq_d = dq_reg;
  assign link.dq_d_oe = oe_reg;
  // four strobes, one per nine lanes
  assign link.read_data_strobe = {RSTB_N{rstb_reg}};
  assign burst_code_o = code_reg;
  assign refresh_pulse_o = rpulse_reg;
  assign refresh_bank_o = rbank_reg;
  assign refresh_row_o = rrow_reg;
  assign write_pulse_o = wpulse_reg;
endmodule // dbm_device_end
`default_nettype wire

// ===== hdl/dbm_host_end.sv
// Controller end: issues commands, streams write data, gathers read data.
`timescale 1ns/100ps
`default_nettype none
module dbm_host_end
  import dbm_pkg::*;
#(
  parameter int REFI = REFI_CYC
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  dbm_link_if.host_mp link,
  input wire logic cmd_valid_i,
  input wire dbm_op_t cmd_op_i,
  input wire logic [BANK_W-1:0] cmd_bank_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [MASK_W-1:0] cmd_mask_i,
  output logic cmd_ready_o,
  input wire logic [DQ_W-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [DQ_W-1:0] rd_data_o,
  output logic rd_valid_o
);
  typedef enum logic [2:0] {HS_IDLE, HS_ISSUE, HS_WBURST, HS_WEND, HS_RWAIT, HS_HOLD} dbm_hstate_t;
  logic [DQ_W-1:0] f_data;
  logic f_valid;
  logic f_pop;
  logic [BEAT_W-1:0] f_count;

  dbm_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) dbm_fifo_i (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(wr_data_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .count_o(f_count)
  );

  // ****************************************
  // Read return synchronisers
  // ****************************************
  logic [SYNC_HOST_W-1:0] sync1_reg, sync2_reg;
  logic [1:0] rs_d_reg;
  logic [1:0] rs_s;
  logic [DQ_W-1:0] dq_s;
  logic [1:0] redge;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      rs_d_reg <= '0;
    end else begin
      // only strobes zero and one
      sync1_reg <= {link.read_data_strobe[1:0], link.dq};
      sync2_reg <= sync1_reg;
      rs_d_reg <= rs_s;
    end
  end

  always_comb begin
    {rs_s, dq_s} = sync2_reg;
    redge = rs_s ^ rs_d_reg;
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  dbm_hstate_t state_reg, state_next;
  logic [2:0] ph_reg, ph_next;
  logic ck_reg, ck_next;
  logic [2:0] pins_reg, pins_next;
  logic [BANK_W-1:0] bank_reg, bank_next, pbank_reg, pbank_next;
  logic [ADDR_W-1:0] addr_reg, addr_next, paddr_reg, paddr_next;
  logic [MASK_W-1:0] mask_reg, mask_next, wmask_reg, wmask_next;
  dbm_op_t op_reg, op_next;
  logic [1:0] code_reg, code_next;
  logic [BEAT_W-1:0] beat_reg, beat_next, n_beats;
  logic [DQ_W-1:0] dqo_reg, dqo_next, lanes_reg, lanes_next, rd_reg, rd_next;
  logic oe_reg, oe_next, wstb_reg, wstb_next, rdy_reg, rdy_next, rv_reg, rv_next;
  logic [31:0] rt_reg, rt_next;
  logic pend_reg, pend_next, pend_clr;
  logic [BANK_W-1:0] rfb_reg, rfb_next;

  always_comb begin
    state_next = state_reg;
    ph_next = (ph_reg == PH_LAST) ? 3'h0 : ph_reg + 3'h1;
    ck_next = (ph_next < PH_FALL);
    pins_next = pins_reg;
    bank_next = bank_reg;
    addr_next = addr_reg;
    mask_next = mask_reg;
    op_next = op_reg;
    pbank_next = pbank_reg;
    paddr_next = paddr_reg;
    wmask_next = wmask_reg;
    code_next = code_reg;
    beat_next = beat_reg;
    dqo_next = dqo_reg;
    lanes_next = lanes_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    wstb_next = wstb_reg;
    rv_next = 1'b0;
    f_pop = 1'b0;
    pend_clr = 1'b0;
    rfb_next = rfb_reg;
    n_beats = dbm_burst_beat_count(code_reg);
    rt_next = (rt_reg >= 32'(REFI - 1)) ? '0 : rt_reg + 32'h1;
    // pins change at fall, stable at rise
    if (ph_reg == PH_FALL) begin
      pins_next = PINS_NOP;
    end
    case (state_reg)
      HS_IDLE: begin
        if (rdy_reg && cmd_valid_i) begin
          op_next = cmd_op_i;
          bank_next = cmd_bank_i;
          addr_next = cmd_addr_i;
          mask_next = cmd_mask_i;
          state_next = HS_ISSUE;
        end else if (pend_reg) begin
          op_next = OP_REFRESH;
          bank_next = rfb_reg;
          rfb_next = rfb_reg + BANK_W'(1);
          pend_clr = 1'b1;
          state_next = HS_ISSUE;
        end
      end
      HS_ISSUE: begin
        if (ph_reg == PH_FALL && (op_reg != OP_WRITE || f_count >= n_beats)) begin
          // only defined encodings; full address each command
          pins_next = dbm_pins(op_reg);
          pbank_next = bank_reg;
          paddr_next = addr_reg;
          beat_next = '0;
          if (op_reg == OP_MODE && addr_reg[1:0] != LEN_CODE_BAD) begin
            code_next = addr_reg[1:0];
          end
          if (op_reg == OP_WRITE) begin
            state_next = HS_WBURST;
          end else if (op_reg == OP_READ) begin
            state_next = HS_RWAIT;
          end else begin
            state_next = HS_HOLD;
          end
        end
      end
      HS_WBURST: begin
        // data at link clock edges, strobe mid-beat
        if (ph_reg[1:0] == 2'h0 && f_valid) begin
          dqo_next = f_data;
          oe_next = 1'b1;
          f_pop = 1'b1;
          wmask_next = mask_reg;
        end
        if (ph_reg[1:0] == 2'h2 && oe_reg) begin
          wstb_next = ~wstb_reg;
          beat_next = beat_reg + 4'h1;
          if (beat_reg + 4'h1 == n_beats) begin
            state_next = HS_WEND;
          end
        end
      end
      HS_WEND: begin
        if (ph_reg[1:0] == 2'h0) begin
          oe_next = 1'b0;
          wmask_next = '0;
          state_next = HS_IDLE;
        end
      end
      HS_RWAIT: begin
        if (redge[0]) begin
          lanes_next = dq_s;
        end
        if (redge[1]) begin
          rd_next = dq_s;
          rd_next[8:0] = redge[0] ? dq_s[8:0] : lanes_reg[8:0];
          rd_next[26:18] = redge[0] ? dq_s[26:18] : lanes_reg[26:18];
          rv_next = 1'b1;
          beat_next = beat_reg + 4'h1;
          if (beat_reg + 4'h1 == n_beats) begin
            state_next = HS_IDLE;
          end
        end
      end
      HS_HOLD: begin
        if (ph_reg == PH_FALL) begin
          state_next = HS_IDLE;
        end
      end
      default: begin
        state_next = HS_IDLE;
      end
    endcase
    // Refresh tick wins over the clear.
    pend_next = (rt_reg == '0) ? 1'b1 : (pend_clr ? 1'b0 : pend_reg);
    rdy_next = (state_next == HS_IDLE) && !pend_next;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // device assumed with locked loop enabled from start
      state_reg <= HS_IDLE;
      ph_reg <= PH_LAST;
      ck_reg <= 1'b0;
      pins_reg <= PINS_NOP;
      bank_reg <= '0;
      addr_reg <= '0;
      mask_reg <= '0;
      op_reg <= OP_READ;
      pbank_reg <= '0;
      paddr_reg <= '0;
      wmask_reg <= '0;
      code_reg <= LEN_CODE_RST;
      beat_reg <= '0;
      dqo_reg <= '0;
      lanes_reg <= '0;
      rd_reg <= '0;
      oe_reg <= 1'b0;
      wstb_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rt_reg <= 32'h1;
      pend_reg <= 1'b0;
      rfb_reg <= '0;
    end else begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      ck_reg <= ck_next;
      pins_reg <= pins_next;
      bank_reg <= bank_next;
      addr_reg <= addr_next;
      mask_reg <= mask_next;
      op_reg <= op_next;
      pbank_reg <= pbank_next;
      paddr_reg <= paddr_next;
      wmask_reg <= wmask_next;
      code_reg <= code_next;
      beat_reg <= beat_next;
      dqo_reg <= dqo_next;
      lanes_reg <= lanes_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      wstb_reg <= wstb_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rt_reg <= rt_next;
      pend_reg <= pend_next;
      rfb_reg <= rfb_next;
    end
  end

  assign link.ck = ck_reg;
  assign {link.cs_n, link.we_n, link.ref_n} = pins_reg;
  assign link.bank = pbank_reg;
  assign link.addr = paddr_reg;
  assign link.write_byte_mask = wmask_reg;
  assign link.write_data_strobe = {WSTB_N{wstb_reg}};
  assign link.dq_h = dqo_reg;
  assign link.dq_h_oe = oe_reg;
  assign cmd_ready_o = rdy_reg;
  assign rd_data_o = rd_reg;
  assign rd_valid_o = rv_reg;
endmodule // dbm_host_end
`default_nettype wire

// ===== tb/dbm_link_properties.sv
// Protocol checker of the link between the two ends.
`timescale 1ns/100ps
`default_nettype none
module dbm_link_properties
  import dbm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [WSTB_N-1:0] write_data_strobe,
  input wire logic [RSTB_N-1:0] read_data_strobe,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ****
  // Properties
  // ****
  property p_ck_shape; $rose(ck) |-> ck[*4] ##1 !ck[*4] ##1 ck; endproperty
  a_ck_shape: assert property (p_ck_shape) else $error("ck shape");
  property p_pins; $changed({cs_n, we_n, ref_n}) |-> !ck && !$past(ck) && $past(ck, 2); endproperty
  a_pins: assert property (p_pins) else $error("pins off ck fall");
  property p_clash; !(dq_h_oe && dq_d_oe); endproperty
  a_clash: assert property (p_clash) else $error("both drive dq");
  property p_rstb_eq; (&read_data_strobe) == (|read_data_strobe); endproperty
  a_rstb_eq: assert property (p_rstb_eq) else $error("read strobes differ");
  property p_rstb_oe; $changed(read_data_strobe) |-> dq_d_oe; endproperty
  a_rstb_oe: assert property (p_rstb_oe) else $error("strobe without data");
  property p_rstb_step; $changed(read_data_strobe) |-> ##4 ($changed(read_data_strobe) || !dq_d_oe); endproperty
  a_rstb_step: assert property (p_rstb_step) else $error("read beat gap");
  property p_wstb_oe; $changed(write_data_strobe) |-> dq_h_oe && (&write_data_strobe == |write_data_strobe); endproperty
  a_wstb_oe: assert property (p_wstb_oe) else $error("write strobe");
  property p_oe_len; $rose(dq_d_oe) |-> ##[4:40] !dq_d_oe; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read burst length");
  c_read: cover property ($rose(dq_d_oe));
  c_write: cover property ($rose(dq_h_oe));
  c_ref: cover property (!ref_n && !cs_n);
endmodule // dbm_link_properties
`default_nettype wire

// ===== tb/ddr_burst_memory_port_tb.sv
// Self-checking bench of both link ends.
`timescale 1ns/100ps
`default_nettype none
module ddr_burst_memory_port_tb
  import dbm_pkg::*;
;
  logic core_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic cmd_valid_i = 1'h0;
  logic wr_valid_i = 1'h0;
  dbm_op_t cmd_op_i = OP_READ;
  logic [BANK_W-1:0] cmd_bank_i = '0;
  logic [ADDR_W-1:0] cmd_addr_i = '0;
  logic [MASK_W-1:0] cmd_mask_i = '0;
  logic [DQ_W-1:0] wr_data_i = '0;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, refresh_pulse_o;
  logic [DQ_W-1:0] rd_data_o;
  logic [1:0] burst_code_o;
  logic [BANK_W-1:0] refresh_bank_o;
  logic [ROW_W-1:0] refresh_row_o;
  logic write_pulse_o;
  int n_wbeats = 0;
  int n_errors = 0;
  int n_checks = 0;
  dbm_link_if link ();
  dbm_host_end #(.REFI(200)) dbm_host_end_i (.core_clk_i, .nrst_i, .link, .cmd_valid_i,
    .cmd_op_i, .cmd_bank_i, .cmd_addr_i, .cmd_mask_i, .cmd_ready_o, .wr_data_i,
    .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o);
  dbm_device_end dbm_device_end_i (.core_clk_i, .nrst_i, .link, .burst_code_o,
    .refresh_pulse_o, .refresh_bank_o, .refresh_row_o, .write_pulse_o);
  dbm_link_properties chk_i (.core_clk_i, .nrst_i, .ck(link.ck), .cs_n(link.cs_n),
    .we_n(link.we_n), .ref_n(link.ref_n), .write_data_strobe(link.write_data_strobe),
    .read_data_strobe(link.read_data_strobe), .dq_h_oe(link.dq_h_oe), .dq_d_oe(link.dq_d_oe));
  always #50 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) begin
    if (write_pulse_o === 1'h1) n_wbeats++;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [DQ_W-1:0] pat(input int b, input int a, input int i);
    return {4'hA, 4'(b), 4'(a), 8'(i), 16'h5C3E};
  endfunction
  task automatic cmd(input dbm_op_t op, input int b, input int a, input int m);
    @(negedge core_clk_i);
    cmd_op_i = op;
    cmd_bank_i = 4'(b);
    cmd_addr_i = 4'(a);
    cmd_mask_i = 2'(m);
    cmd_valid_i = 1'h1;
    while (cmd_ready_o !== 1'h1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    cmd_valid_i = 1'h0;
  endtask
  task automatic push(input logic [DQ_W-1:0] d);
    @(negedge core_clk_i);
    wr_data_i = d;
    wr_valid_i = 1'h1;
    while (wr_ready_o !== 1'h1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    wr_valid_i = 1'h0;
  endtask
  task automatic burst(input logic [1:0] code, input int b, input int a, input int m);
    int n, i, t, w0;
    logic [DQ_W-1:0] w;
    n = 2 << code;
    w0 = n_wbeats;
    cmd(OP_MODE, 0, code, 0);
    for (i = 0; i < n; i++) push(pat(b, a, i));
    if (n == FIFO_DEPTH) check(wr_ready_o, 0);
    cmd(OP_WRITE, b, a, 0);
    for (i = 0; i < n; i++) push(~pat(b, a, i));
    cmd(OP_WRITE, b, a, m);
    cmd(OP_READ, b, a, 0);
    for (i = 0; i < n; i++) begin
      for (t = 0; t < 200 && rd_valid_o !== 1'h1; t++) @(negedge core_clk_i);
      check(rd_valid_o, 1);
      w = pat(b, a, i);
      check(rd_data_o, {m[1] ? w[35:18] : ~w[35:18], m[0] ? w[17:0] : ~w[17:0]});
      @(negedge core_clk_i);
    end
    check(n_wbeats - w0, 2 * n);
    check(burst_code_o, code);
    check(wr_ready_o, 1);
    $display("burst of %0d done", n);
  endtask
  task automatic refresh_rows;
    logic [BANK_W-1:0] b0;
    logic [ROW_W-1:0] r0;
    int k;
    for (k = 0; k < 17; k++) begin
      do @(negedge core_clk_i); while (refresh_pulse_o !== 1'h1);
      if (k == 0) {b0, r0} = {refresh_bank_o, refresh_row_o};
    end
    check(refresh_bank_o, b0);
    check(refresh_row_o, r0 + 13'h1);
    $display("refresh done");
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (10) @(negedge core_clk_i);
    nrst_i = 1'h1;
    burst(LEN_CODE_2, 3, 5, 0);
    burst(LEN_CODE_4, 9, 14, 1);
    burst(LEN_CODE_8, 15, 12, 2);
    refresh_rows;
    cmd(OP_MODE, 0, 3, 0);
    cmd(OP_REFRESH, 2, 0, 0);
    check(burst_code_o, LEN_CODE_8);
    $display("bad length done");
    tally_and_finish;
  end
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
endmodule // ddr_burst_memory_port_tb
`default_nettype wire
